// file: hdl/oss_consts.svh
/*
 * constants of the oscillator step register bank: offsets, fields, resets.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef OSS_CONSTS_SVH
`define OSS_CONSTS_SVH

`define OSS_OFS_STEP_LOW    12'h000
`define OSS_OFS_STEP_HIGH   12'h004
`define OSS_OFS_STEP_UPPER  12'h008
`define OSS_OFS_PHASE_ACC   12'h00c
`define OSS_OFS_CONTROL     12'h010

`define OSS_STEP_W          20
`define OSS_UPPER_W         4
`define OSS_RST_LOW         8'h01
`define OSS_RST_HIGH        8'h00
`define OSS_RST_UPPER       4'h0
`define OSS_RST_ACC         20'h00000
`define OSS_CTL_EN_BIT      0

`define OSS_RESP_OKAY       2'b00
`define OSS_RESP_SLVERR     2'b10

`endif

// file: hdl/oss_pkg.sv
/*
 * types of the oscillator step register bank.
 * assumes oss_consts.svh is on the include path.
 */
`include "oss_consts.svh"

package oss_pkg;
    typedef struct packed {
        logic [`OSS_UPPER_W-1:0] upper;
        logic [7:0]              high;
        logic [7:0]              low;
    } oss_step_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        valid;
    } oss_addr_t;
endpackage

// file: hdl/oss_step_regs.sv
/*
 * oscillator step register bank with axi4-lite slave, shadow step word and
 * 20-bit phase accumulator.
 * assumes the oscillator source clock arrives unsynchronised on a pin and is
 * far slower than ref_clk; single ref_clk domain, synchronous active-low reset.
 */
// The address map and the AXI4-Lite slave port were left to the implementer.
// Overview of operation
// R1 - The 20-bit step value is low byte bits 7..0, high byte bits 15..8 and upper register bits 3..0 for 19..16.
// R2 - Upper register bits 7..4 ignore writes and read as zero.
// R3 - A shadow copy of the step is loaded on the first falling source clock edge after a low byte write.
// R4 - Software writes upper and high bytes before the low byte, as only the low write triggers the transfer.
// R5 - Reset loads the step value with one, low bit 0 set and all else clear.
// R6 - The accumulator runs on its own clock and is not written while the oscillator runs; the code clocks it by ref_clk on synchronised source edges.
// R7 - Each active source clock edge adds the shadow step to the accumulator, dropping the carry.
`timescale 1ns/1ps
`default_nettype none
`include "oss_consts.svh"

module oss_step_regs (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    osc_source_clock,
    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [`OSS_STEP_W-1:0]       synth_step_word,
    output logic [`OSS_STEP_W-1:0]       phase_accumulator
);
    function automatic logic [`OSS_STEP_W-1:0] merge_bytes(input logic [`OSS_STEP_W-1:0] old,
                                                           input logic [31:0] data, input logic [3:0] strb);
        logic [`OSS_STEP_W-1:0] res;
        res = old;
        if (strb[0]) res[7:0] = data[7:0];
        if (strb[1]) res[15:8] = data[15:8];
        if (strb[2]) res[19:16] = data[19:16];
        return res;
    endfunction

    oss_pkg::oss_step_t        step_q;
    logic [`OSS_STEP_W-1:0]    shadow_q;
    logic [`OSS_STEP_W-1:0]    acc_q;
    logic                      run_q;
    logic                      load_pend_q;
    logic                      src_s1_q, src_s2_q, src_s3_q;
    oss_pkg::oss_addr_t        aw_q;
    logic [31:0]               wdata_q;
    logic [3:0]                wstrb_q;
    logic                      w_have_q;
    logic                      awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]                bresp_q, rresp_q;
    logic [31:0]               rdata_q;

    // source clock falling edge, taken from the second and third stages only
    wire src_fall = src_s3_q & ~src_s2_q;
    wire aw_hs    = s_axi_awvalid & awready_q;
    wire w_hs     = s_axi_wvalid & wready_q;
    wire ar_hs    = s_axi_arvalid & arready_q;
    wire do_write = aw_q.valid & w_have_q & ~bvalid_q;

    wire wr_low   = do_write && aw_q.addr == `OSS_OFS_STEP_LOW   && wstrb_q[0];
    wire wr_high  = do_write && aw_q.addr == `OSS_OFS_STEP_HIGH  && wstrb_q[0];
    wire wr_upper = do_write && aw_q.addr == `OSS_OFS_STEP_UPPER && wstrb_q[0];
    wire wr_acc   = do_write && aw_q.addr == `OSS_OFS_PHASE_ACC && !run_q;
    wire wr_ctl   = do_write && aw_q.addr == `OSS_OFS_CONTROL   && wstrb_q[0];
    wire wr_hit   = aw_q.addr == `OSS_OFS_STEP_LOW || aw_q.addr == `OSS_OFS_STEP_HIGH
                 || aw_q.addr == `OSS_OFS_STEP_UPPER || aw_q.addr == `OSS_OFS_PHASE_ACC
                 || aw_q.addr == `OSS_OFS_CONTROL;

    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        if (s_axi_araddr == `OSS_OFS_STEP_LOW) begin
            rd_word = {24'h000000, step_q.low};
        end else if (s_axi_araddr == `OSS_OFS_STEP_HIGH) begin
            rd_word = {24'h000000, step_q.high};
        end else if (s_axi_araddr == `OSS_OFS_STEP_UPPER) begin
            rd_word = {28'h0000000, step_q.upper};                 // [R2]
        end else if (s_axi_araddr == `OSS_OFS_PHASE_ACC) begin
            rd_word = {12'h000, acc_q};
        end else if (s_axi_araddr == `OSS_OFS_CONTROL) begin
            rd_word = {30'h00000000, load_pend_q, run_q};
        end else begin
            rd_word = 32'h00000000;
            rd_hit  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        src_s1_q <= osc_source_clock;
        src_s2_q <= src_s1_q;
        src_s3_q <= src_s2_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            step_q.low   <= `OSS_RST_LOW;                          // [R5]
            step_q.high  <= `OSS_RST_HIGH;
            step_q.upper <= `OSS_RST_UPPER;
            run_q        <= 1'b0;
        end else begin
            if (wr_low)   step_q.low   <= wdata_q[7:0];
            if (wr_high)  step_q.high  <= wdata_q[7:0];
            if (wr_upper) step_q.upper <= wdata_q[`OSS_UPPER_W-1:0]; // [R2]
            if (wr_ctl)   run_q        <= wdata_q[`OSS_CTL_EN_BIT];
        end
    end

    // shadow and accumulator; a low write in the load cycle keeps the request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shadow_q    <= {`OSS_RST_UPPER, `OSS_RST_HIGH, `OSS_RST_LOW}; // [R5]
            load_pend_q <= 1'b0;
            acc_q       <= `OSS_RST_ACC;
        end else begin
            load_pend_q <= wr_low | (load_pend_q & ~src_fall);       // [R3] [R4]
            if (load_pend_q && src_fall)
                shadow_q <= step_q;                                  // [R1] [R3]
            if (wr_acc)
                acc_q <= merge_bytes(acc_q, wdata_q, wstrb_q);       // [R6]
            else if (run_q && src_fall)
                acc_q <= acc_q + shadow_q;                           // [R7]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_q      <= '0;
            w_have_q  <= 1'b0;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `OSS_RESP_OKAY;
        end else begin
            awready_q <= ~aw_q.valid & ~aw_hs & ~bvalid_q;
            wready_q  <= ~w_have_q & ~w_hs & ~bvalid_q;
            if (aw_hs) aw_q <= '{addr: s_axi_awaddr, valid: 1'b1};
            if (w_hs) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (do_write) begin
                bvalid_q   <= 1'b1;
                bresp_q    <= wr_hit ? `OSS_RESP_OKAY : `OSS_RESP_SLVERR;
                aw_q.valid <= 1'b0;
                w_have_q   <= 1'b0;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `OSS_RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_q & ~ar_hs;
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_hit ? `OSS_RESP_OKAY : `OSS_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready     = awready_q;
    assign s_axi_wready      = wready_q;
    assign s_axi_bvalid      = bvalid_q;
    assign s_axi_bresp       = bresp_q;
    assign s_axi_arready     = arready_q;
    assign s_axi_rvalid      = rvalid_q;
    assign s_axi_rdata       = rdata_q;
    assign s_axi_rresp       = rresp_q;
    assign synth_step_word   = shadow_q;
    assign phase_accumulator = acc_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_shadow_load_map: assert property (load_pend_q && src_fall |=>               // [R1]
        shadow_q == {$past(step_q.upper), $past(step_q.high), $past(step_q.low)})
        else $error("shadow not loaded from the three step bytes");
    a_upper_reads_zero: assert property (ar_hs && s_axi_araddr == `OSS_OFS_STEP_UPPER // [R2]
        |=> rdata_q[31:`OSS_UPPER_W] == '0)
        else $error("upper step register high bits not zero");
    a_shadow_wait_edge: assert property (!(load_pend_q && src_fall) |=> $stable(shadow_q)) // [R3]
        else $error("shadow changed without a pending load and edge");
    a_low_arms_load: assert property (wr_low |=> load_pend_q)                      // [R3]
        else $error("low byte write did not request a shadow load");
    a_reset_step_one: assert property ($rose(rst_n) |->                             // [R5]
        step_q == {`OSS_RST_UPPER, `OSS_RST_HIGH, `OSS_RST_LOW} && shadow_q == 20'h00001)
        else $error("step value not one after reset");
    a_acc_locked_run: assert property (run_q && !src_fall |=> $stable(acc_q))      // [R6]
        else $error("accumulator changed while running without an edge");
    a_acc_adds_step: assert property (run_q && src_fall && !wr_acc |=>             // [R7]
        acc_q == 20'($past(acc_q) + $past(shadow_q)))
        else $error("accumulator did not add the shadow step");
    a_write_answer: assert property (aw_hs && w_hs |=> ##1 bvalid_q)               // AXI write response timing, not one of R1-R7
        else $error("write response not given two cycles after the request");

    c_low_write_load: cover property (wr_low ##[1:1000] (load_pend_q && src_fall));
    c_acc_wraps: cover property (run_q && src_fall && acc_q > 20'(acc_q + shadow_q));
    c_bad_read: cover property (ar_hs && !rd_hit);
endmodule
`default_nettype wire

// file: verif/testbench.sv
/*
 * self-checking bench for the oscillator step register bank over axi4-lite.
 * assumes oss_step_regs with the offsets of oss_consts.svh; drives the source clock itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "oss_consts.svh"

module testbench;
    logic        ref_clk = 0, rst_n = 0, osc_source_clock = 1;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [19:0] synth_step_word, phase_accumulator;
    int          n_mismatch = 0, tests_run = 0;

    oss_step_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .osc_source_clock(osc_source_clock),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .synth_step_word(synth_step_word), .phase_accumulator(phase_accumulator));

    always #5 ref_clk = ~ref_clk;

    task automatic test_done;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang;
        n_mismatch++;
        $display("CHECK FAILED %0t: bus answer never came", $time);
        test_done();
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int n;
        n = 0;
        r = 2'bxx;
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d; s_axi_wstrb <= s;
        s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (n < 100) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 0;
                n = 200;
            end
        end
        if (n != 200) hang();
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        while (n < 100) begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata; r = s_axi_rresp;
                s_axi_rready <= 0;
                n = 200;
            end
        end
        if (n != 200) hang();
    endtask

    task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hf, r);
        chk(32'(r), 32'(`OSS_RESP_OKAY));
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(32'(r), 32'(`OSS_RESP_OKAY));
        chk(d, exp);
    endtask

    // one source clock period, falling edge first
    task automatic src_fall;
        @(posedge ref_clk);
        osc_source_clock <= 0;
        repeat (8) @(posedge ref_clk);
        osc_source_clock <= 1;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic t_reset;
        rd_chk(`OSS_OFS_STEP_LOW, 32'h01);
        rd_chk(`OSS_OFS_STEP_HIGH, 32'h00);
        rd_chk(`OSS_OFS_STEP_UPPER, 32'h00);
        chk(32'(synth_step_word), 32'h00001);
        chk(32'(phase_accumulator), 32'h0);
    endtask

    task automatic t_shadow;
        wr_ok(`OSS_OFS_STEP_UPPER, 32'hff);
        rd_chk(`OSS_OFS_STEP_UPPER, 32'h0f);
        wr_ok(`OSS_OFS_STEP_HIGH, 32'h34);
        src_fall();
        chk(32'(synth_step_word), 32'h00001);
        wr_ok(`OSS_OFS_STEP_LOW, 32'h56);
        chk(32'(synth_step_word), 32'h00001);
        rd_chk(`OSS_OFS_CONTROL, 32'h2);
        src_fall();
        chk(32'(synth_step_word), 32'hf3456);
        rd_chk(`OSS_OFS_CONTROL, 32'h0);
    endtask

    task automatic t_accum;
        logic [19:0] exp;
        exp = 20'h12345;
        wr_ok(`OSS_OFS_PHASE_ACC, 32'h12345);
        rd_chk(`OSS_OFS_PHASE_ACC, 32'h12345);
        wr_ok(`OSS_OFS_CONTROL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            src_fall();
            exp = exp + 20'hf3456;
            chk(32'(phase_accumulator), 32'(exp));
        end
        wr_ok(`OSS_OFS_PHASE_ACC, 32'habcde);
        chk(32'(phase_accumulator), 32'(exp));
        wr_ok(`OSS_OFS_CONTROL, 32'h0);
        src_fall();
        rd_chk(`OSS_OFS_PHASE_ACC, 32'(exp));
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(12'h020, 32'h5a, 4'hf, r);
        chk(32'(r), 32'(`OSS_RESP_SLVERR));
        axi_rd(12'h020, d, r);
        chk(32'(r), 32'(`OSS_RESP_SLVERR));
        chk(d, 32'h0);
        rd_chk(`OSS_OFS_STEP_LOW, 32'h56);
    endtask

    // reset after the run is stopped must bring back step one, shadow one and a clear accumulator
    task automatic t_rereset;
        @(posedge ref_clk);
        rst_n <= 0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1;
        t_reset();
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1;
        t_reset();
        t_shadow();
        t_accum();
        t_unmapped();
        t_rereset();
        test_done();
    end
endmodule
`default_nettype wire
